// *** clock_select_and_standby_control.sv ***
// clock source selection, gearing, prescaler and standby mode control
//
// Behaviour
// [RULE1] low power field: 001 stop, 010 sleep, 011 idle, others reserved
// [RULE2] bit 16 keeps pins driven in stop when 1; resets to 0
// [RULE3] bit 9 keeps slow oscillator running after stop release; resets to 0
// [RULE4] bit 8 keeps fast oscillator running after stop release; resets to 1
// [RULE5] pll selection bit 0 set routes pll clock to fast core clock
// [RULE6] reset selects crystal as fast core clock; software sets pll use
// [RULE7] system select bit 1: 0 geared fast, 1 slow crystal; resets 0
// [RULE8] software enables both oscillators before changing system clock selection
// [RULE9] read-only status bit 0 shows current system clock source
// [RULE10] source change completes after lag; software polls status bit
// [RULE11] pll clock runs four times the crystal clock
// [RULE12] fast core clock divided by 1, 2, 4 or 8 gives geared clock
// [RULE13] prescaler tap is peripheral base clock divided by 1 to 32
// [RULE14] bus and free clocks equal system clock; tick is crystal over 32
// [RULE15] bus and free clocks stop in any low power mode
// [RULE16] reset: both oscillators run, pll stopped, gear undivided
// [RULE17] after reset fast core, system and tap clocks equal crystal clock
// [RULE18] gear codes 000 /1, 100 /2, 101 /4, 110 /8; others reserved
// [RULE19] tap codes 000 to 101 divide by 1 to 32; 110, 111 reserved
// [RULE20] pll stopped after reset, runs only when run bit 2 set
// [RULE21] source multiplexers switch on safe edges; status follows actual source
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`default_nettype none
module clock_select_and_standby_control (
   input  wire logic                       clk,
   input  wire logic                       nrst,
   input  wire clock_ctrl_pkg::avmm_req_t  avmReq,
   output logic [31:0]                     readdata,
   output logic                            waitrequest,
   input  wire logic                       slowXtalPin,
   input  wire logic                       lowPowerEnter,
   input  wire logic                       wakeUp,
   output clock_ctrl_pkg::clk_enables_t    clkEn,
   output logic                            hiOscRun,
   output logic                            loOscRun,
   output logic                            pll_run,
   output logic                            pinsDriven,
   output clock_ctrl_pkg::power_state_t    powerState
);
   import clock_ctrl_pkg::*;

   logic       ack;
   logic       hiOscEn;
   logic       loOscEn;
   logic       pllRun;
   logic [2:0] gearSel;
   logic [2:0] tapSel;
   logic       periphSel;
   logic [2:0] lowPowerSelect;
   logic       stopPinDrive;
   logic       loOscAfterWake;
   logic       hiOscAfterWake;
   logic       pllClockUse;
   logic       pllActive;
   logic       sysReq;
   logic       sysCurrent;
   logic       gearSeen;
   logic       slowSeen;
   logic       s1;
   logic       s2;
   logic       s3;
   logic       slowLevel;
   logic       oscPulse;
   logic       pllPulse;
   logic       fastPulse;
   logic       gearPulse;
   logic       slowPulse;
   logic       tickPulse;
   logic       periphPulse;
   logic       tapPulse;
   logic       sysPulse;
   logic       lowPower;
   logic [2:0] gearShift;
   logic [2:0] tapShift;
   logic       wrStrobe;
   logic [31:0] next_readdata;

   // one wait cycle per access; a write lands on the answering edge
   assign waitrequest = (avmReq.read || avmReq.write) && !ack;
   assign wrStrobe    = avmReq.write && ack;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ack <= 1'b0;
      end else begin
         ack <= (avmReq.read || avmReq.write) && !ack;
      end
   end

   always_comb begin
      next_readdata = 32'h0000_0000;
      unique case (avmReq.address)
         OSC_CTRL_ADDR: begin
            next_readdata[HI_OSC_BIT]  = hiOscEn;
            next_readdata[LO_OSC_BIT]  = loOscEn;
            next_readdata[PLL_RUN_BIT] = pllRun;
         end
         SYS_CONFIG_ADDR: begin
            next_readdata[GEAR_LSB +: 3]  = gearSel;
            next_readdata[TAP_LSB +: 3]   = tapSel;
            next_readdata[PERIPH_SEL_BIT] = periphSel;
         end
         STANDBY_ADDR: begin
            next_readdata[LOW_POWER_LSB +: 3] = lowPowerSelect;
            next_readdata[HI_WAKE_BIT]        = hiOscAfterWake;
            next_readdata[LO_WAKE_BIT]        = loOscAfterWake;
            next_readdata[PIN_DRIVE_BIT]      = stopPinDrive;
         end
         PLL_SEL_ADDR: begin
            next_readdata[PLL_USE_BIT] = pllClockUse;
         end
         SYS_CLK_SEL_ADDR: begin
            next_readdata[SYS_REQ_BIT]    = sysReq;
            next_readdata[SYS_STATUS_BIT] = sysCurrent; // RULE9
         end
         default: begin
            next_readdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         readdata <= 32'h0000_0000;
      end else if (avmReq.read && !ack) begin
         readdata <= next_readdata;
      end
   end

   // standby control register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         lowPowerSelect <= STANDBY_RESET;
         stopPinDrive   <= 1'b0; // RULE2
         loOscAfterWake <= 1'b0; // RULE3
         hiOscAfterWake <= HI_WAKE_RESET; // RULE4
      end else if (wrStrobe && avmReq.address == STANDBY_ADDR) begin
         lowPowerSelect <= avmReq.writedata[LOW_POWER_LSB +: 3];
         stopPinDrive   <= avmReq.writedata[PIN_DRIVE_BIT];
         loOscAfterWake <= avmReq.writedata[LO_WAKE_BIT];
         hiOscAfterWake <= avmReq.writedata[HI_WAKE_BIT];
      end
   end

   // system configuration register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         gearSel   <= GEAR_DIV1; // RULE16 RULE17
         tapSel    <= 3'h0; // RULE17
         periphSel <= 1'b0;
      end else if (wrStrobe && avmReq.address == SYS_CONFIG_ADDR) begin
         gearSel   <= avmReq.writedata[GEAR_LSB +: 3];
         tapSel    <= avmReq.writedata[TAP_LSB +: 3];
         periphSel <= avmReq.writedata[PERIPH_SEL_BIT];
      end
   end

   // pll selection and system clock request
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pllClockUse <= 1'b0; // RULE6
         sysReq      <= 1'b0; // RULE7
      end else if (wrStrobe && avmReq.address == PLL_SEL_ADDR) begin
         pllClockUse <= avmReq.writedata[PLL_USE_BIT]; // RULE5
      end else if (wrStrobe && avmReq.address == SYS_CLK_SEL_ADDR) begin
         sysReq <= avmReq.writedata[SYS_REQ_BIT]; // RULE7 RULE8
      end
   end

   // oscillator control, with the stop release reload
   always_ff @(posedge clk) begin
      if (!nrst) begin
         hiOscEn <= 1'b1; // RULE16
         loOscEn <= 1'b1; // RULE16
         pllRun  <= 1'b0; // RULE20
      end else if (powerState == STOP && wakeUp) begin
         hiOscEn <= hiOscAfterWake; // RULE4
         loOscEn <= loOscAfterWake; // RULE3
      end else if (wrStrobe && avmReq.address == OSC_CTRL_ADDR) begin
         hiOscEn <= avmReq.writedata[HI_OSC_BIT];
         loOscEn <= avmReq.writedata[LO_OSC_BIT];
         pllRun  <= avmReq.writedata[PLL_RUN_BIT]; // RULE20
      end
   end

   // low power state
   always_ff @(posedge clk) begin
      if (!nrst) begin
         powerState <= RUN;
      end else if (powerState == RUN && lowPowerEnter) begin
         unique case (lowPowerSelect)
            LP_STOP:  powerState <= STOP; // RULE1
            LP_SLEEP: powerState <= SLEEP; // RULE1
            LP_IDLE:  powerState <= IDLE; // RULE1
            default:  powerState <= RUN;
         endcase
      end else if (powerState != RUN && wakeUp) begin
         powerState <= RUN;
      end
   end

   assign lowPower   = powerState != RUN;
   assign hiOscRun   = hiOscEn && powerState != STOP;
   assign loOscRun   = loOscEn && powerState != STOP;
   assign pll_run      = pllRun && hiOscRun && powerState != SLEEP; // RULE20
   assign pinsDriven = powerState != STOP || stopPinDrive; // RULE2

   // slow crystal pin synchroniser
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         slowLevel <= 1'b0;
      end else begin
         s1 <= slowXtalPin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            slowLevel <= s3;
         end
      end
   end

   assign slowPulse = loOscRun && s2 == s3 && s3 && !slowLevel;

   // crystal rate is a quarter of clk, pll runs at clk
   clk_en_div oscDiv (
      .clk   (clk),
      .nrst  (nrst),
      .enIn  (hiOscRun),
      .shift (PLL_SHIFT),
      .enOut (oscPulse)
   );
   assign pllPulse = pll_run; // RULE11

   // pll use takes effect only on a crystal edge
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pllActive <= 1'b0; // RULE6
      end else if (oscPulse) begin
         pllActive <= pllClockUse; // RULE21
      end
   end
   assign fastPulse = pllActive ? pllPulse : oscPulse; // RULE5

   always_comb begin
      unique case (gearSel)
         GEAR_DIV2: gearShift = 3'h1; // RULE18
         GEAR_DIV4: gearShift = 3'h2; // RULE18
         GEAR_DIV8: gearShift = 3'h3; // RULE18
         default:   gearShift = 3'h0;
      endcase
   end

   clk_en_div gearDiv (
      .clk   (clk),
      .nrst  (nrst),
      .enIn  (fastPulse),
      .shift (gearShift),
      .enOut (gearPulse)
   ); // RULE12

   // glitch-free system source change: both sources must tick first
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sysCurrent <= 1'b0;
         gearSeen   <= 1'b0;
         slowSeen   <= 1'b0;
      end else if (sysReq == sysCurrent) begin
         gearSeen <= 1'b0;
         slowSeen <= 1'b0;
      end else if ((gearSeen || gearPulse) && (slowSeen || slowPulse)) begin
         sysCurrent <= sysReq; // RULE10 RULE21
         gearSeen   <= 1'b0;
         slowSeen   <= 1'b0;
      end else begin
         gearSeen <= gearSeen || gearPulse;
         slowSeen <= slowSeen || slowPulse;
      end
   end

   assign sysPulse    = sysCurrent ? slowPulse : gearPulse; // RULE7
   assign periphPulse = periphSel ? fastPulse : gearPulse;
   assign tapShift    = tapSel > TAP_MAX ? 3'h0 : tapSel; // RULE19

   clk_en_div tapDiv (
      .clk   (clk),
      .nrst  (nrst),
      .enIn  (periphPulse),
      .shift (tapShift),
      .enOut (tapPulse)
   ); // RULE13

   clk_en_div tickDiv (
      .clk   (clk),
      .nrst  (nrst),
      .enIn  (oscPulse),
      .shift (TICK_SHIFT),
      .enOut (tickPulse)
   ); // RULE14

   assign clkEn.fastCore     = fastPulse;
   assign clkEn.gear         = gearPulse;
   assign clkEn.sys          = sysPulse;
   assign clkEn.bus          = sysPulse && !lowPower; // RULE14 RULE15
   assign clkEn.coreFree     = sysPulse && !lowPower; // RULE14 RULE15
   assign clkEn.periphBase   = periphPulse;
   assign clkEn.prescalerTap = tapPulse;
   assign clkEn.tickTimer    = tickPulse;
   assign clkEn.slowXtal     = slowPulse;

   sequence enterReq_s(logic [2:0] code);
      powerState == RUN && lowPowerEnter && lowPowerSelect == code;
   endsequence

   low_power_stop_a: assert property (@(posedge clk) disable iff (!nrst)
      enterReq_s(LP_STOP) |=> powerState == STOP) // RULE1
      else $error("stop code did not enter stop");
   low_power_idle_a: assert property (@(posedge clk) disable iff (!nrst)
      enterReq_s(LP_IDLE) |=> powerState == IDLE) // RULE1
      else $error("idle code did not enter idle");
   stop_pins_a: assert property (@(posedge clk) disable iff (!nrst)
      powerState == STOP |-> pinsDriven == stopPinDrive) // RULE2
      else $error("pin drive in stop wrong");
   wake_osc_a: assert property (@(posedge clk) disable iff (!nrst)
      powerState == STOP && wakeUp |=> hiOscEn == $past(hiOscAfterWake)
      && loOscEn == $past(loOscAfterWake)) // RULE3 RULE4
      else $error("oscillators wrong after stop release");
   bus_stopped_a: assert property (@(posedge clk) disable iff (!nrst)
      lowPower |-> !clkEn.bus && !clkEn.coreFree) // RULE15
      else $error("bus clock running in low power");
   tick_rate_a: assert property (@(posedge clk) disable iff (!nrst)
      clkEn.tickTimer |-> ##1 !clkEn.tickTimer [*8]) // RULE14
      else $error("tick clock too fast");
   status_source_a: assert property (@(posedge clk) disable iff (!nrst)
      avmReq.read && !ack && avmReq.address == SYS_CLK_SEL_ADDR
      |=> readdata[SYS_STATUS_BIT] == $past(sysCurrent)) // RULE9
      else $error("status does not match source");
   switch_lag_a: assert property (@(posedge clk) disable iff (!nrst)
      $changed(sysCurrent) |-> sysCurrent == $past(sysReq)) // RULE10 RULE21
      else $error("status moved away from request");
   pll_stop_a: assert property (@(posedge clk) disable iff (!nrst)
      !pllRun |-> !pll_run) // RULE20
      else $error("pll running without run bit");
   gear_direct_a: assert property (@(posedge clk) disable iff (!nrst)
      gearSel == GEAR_DIV1 && fastPulse |-> gearPulse) // RULE12 RULE17
      else $error("undivided gear dropped a pulse");
endmodule // clock_select_and_standby_control
`default_nettype wire

// *** clock_ctrl_pkg.sv ***
// constants and carrier types shared by the clock select and standby control block
package clock_ctrl_pkg;
   localparam logic [7:0] OSC_CTRL_ADDR    = 8'h00;
   localparam logic [7:0] SYS_CONFIG_ADDR  = 8'h04;
   localparam logic [7:0] STANDBY_ADDR     = 8'h08;
   localparam logic [7:0] PLL_SEL_ADDR     = 8'h0C;
   localparam logic [7:0] SYS_CLK_SEL_ADDR = 8'h10;

   localparam int LOW_POWER_LSB  = 0;
   localparam int HI_WAKE_BIT    = 8;
   localparam int LO_WAKE_BIT    = 9;
   localparam int PIN_DRIVE_BIT  = 16;
   localparam int PLL_USE_BIT    = 0;
   localparam int SYS_STATUS_BIT = 0;
   localparam int SYS_REQ_BIT    = 1;
   localparam int PLL_RUN_BIT    = 2;
   localparam int HI_OSC_BIT     = 8;
   localparam int LO_OSC_BIT     = 9;
   localparam int GEAR_LSB       = 0;
   localparam int TAP_LSB        = 8;
   localparam int PERIPH_SEL_BIT = 12;

   localparam logic [2:0] LP_STOP  = 3'h1;
   localparam logic [2:0] LP_SLEEP = 3'h2;
   localparam logic [2:0] LP_IDLE  = 3'h3;

   localparam logic [2:0] GEAR_DIV1 = 3'h0;
   localparam logic [2:0] GEAR_DIV2 = 3'h4;
   localparam logic [2:0] GEAR_DIV4 = 3'h5;
   localparam logic [2:0] GEAR_DIV8 = 3'h6;
   localparam logic [2:0] TAP_MAX   = 3'h5;

   localparam logic [2:0] PLL_SHIFT  = 3'h2;
   localparam logic [2:0] TICK_SHIFT = 3'h5;

   localparam logic [2:0] STANDBY_RESET = 3'h0;
   localparam logic       HI_WAKE_RESET = 1'h1;

   typedef enum {RUN, IDLE, SLEEP, STOP} power_state_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
   } avmm_req_t;

   typedef struct packed {
      logic fastCore;
      logic gear;
      logic sys;
      logic bus;
      logic coreFree;
      logic periphBase;
      logic prescalerTap;
      logic tickTimer;
      logic slowXtal;
   } clk_enables_t;
endpackage : clock_ctrl_pkg

// *** clk_en_div.sv ***
// enable-pulse divider by a power of two
`timescale 1ns/10ps
`default_nettype none
module clk_en_div (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       enIn,
   input  wire logic [2:0] shift,
   output logic            enOut
);
   logic [4:0] count;
   logic [4:0] mask;

   assign mask  = 5'((6'h01 << shift) - 6'h01);
   assign enOut = enIn && ((count & mask) == mask);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         count <= 5'h00;
      end else if (enIn) begin
         count <= count + 5'h01;
      end
   end
endmodule // clk_en_div
`default_nettype wire

// *** clock_select_and_standby_control_bench.sv ***
// self-checking testbench for the clock select and standby control block
`timescale 1ns/10ps
`default_nettype none
module clock_select_and_standby_control_bench;
   import clock_ctrl_pkg::*;
   logic         clk;
   logic         nrst;
   avmm_req_t    avmReq;
   logic [31:0]  readdata;
   logic         waitrequest;
   logic         slowXtalPin;
   logic         lowPowerEnter;
   logic         wakeUp;
   clk_enables_t clkEn;
   logic         hiOscRun;
   logic         loOscRun;
   logic         pll_run;
   logic         pinsDriven;
   power_state_t powerState;
   logic [3:0]   slowDiv;
   logic [31:0]  q;
   int           cnts[9];
   int           n_mismatch = 0;
   int           check_count = 0;

   clock_select_and_standby_control clock_select_and_standby_control_i (
      .clk(clk), .nrst(nrst), .avmReq(avmReq), .readdata(readdata),
      .waitrequest(waitrequest), .slowXtalPin(slowXtalPin),
      .lowPowerEnter(lowPowerEnter), .wakeUp(wakeUp), .clkEn(clkEn),
      .hiOscRun(hiOscRun), .loOscRun(loOscRun), .pll_run(pll_run),
      .pinsDriven(pinsDriven), .powerState(powerState));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // slow crystal: one rising edge every 32 clocks
   always @(posedge clk) begin
      slowDiv <= slowDiv + 4'h1;
      if (slowDiv == 4'hF) slowXtalPin <= ~slowXtalPin;
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic busOp(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avmReq <= '{read: !w, write: w, address: a, writedata: d};
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0);
      q = readdata;
      avmReq.read  <= 1'b0;
      avmReq.write <= 1'b0;
      chk("bus cycles", 32'd2, n);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      busOp(1'b1, a, d);
   endtask

   task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
      busOp(1'b0, a, 32'h0);
      chk(name, exp, q);
   endtask

   // counts enable pulses of every clock over a window
   task automatic count(input int cyc);
      logic [8:0] v;
      foreach (cnts[i]) cnts[i] = 0;
      repeat (cyc) begin
         @(negedge clk);
         v = clkEn;
         for (int i = 0; i < 9; i++) if (v[i] === 1'b1) cnts[i]++;
      end
   endtask

   task automatic pulse(input logic enter);
      @(posedge clk);
      if (enter) lowPowerEnter <= 1'b1;
      else wakeUp <= 1'b1;
      @(posedge clk);
      lowPowerEnter <= 1'b0;
      wakeUp <= 1'b0;
      @(negedge clk);
   endtask

   task automatic t_reset();
      rdChk("osc ctrl", OSC_CTRL_ADDR, 32'h00000300);
      rdChk("standby", STANDBY_ADDR, 32'h00000100);
      rdChk("pll select", PLL_SEL_ADDR, 32'h00000000);
      rdChk("sys select", SYS_CLK_SEL_ADDR, 32'h00000000);
      rdChk("unmapped", 8'hFC, 32'h00000000);
      chk("pll_run", 32'h0, {31'h0, pll_run});
      chk("pinsDriven", 32'h1, {31'h0, pinsDriven});
      count(256);
      chk("fastCore", 32'd64, cnts[8]);
      chk("sys", 32'd64, cnts[6]);
      chk("prescalerTap", 32'd64, cnts[2]);
      chk("tickTimer", 32'd2, cnts[1]);
   endtask

   task automatic t_pll();
      wr(OSC_CTRL_ADDR, 32'h00000304);
      wr(PLL_SEL_ADDR, 32'h00000001);
      repeat (8) @(posedge clk);
      chk("pll_run", 32'h1, {31'h0, pll_run});
      count(32);
      chk("fastCore pll", 32'd32, cnts[8]);
      chk("tick pll", 32'd0, cnts[1] > 1);
      wr(PLL_SEL_ADDR, 32'h00000000);
      wr(OSC_CTRL_ADDR, 32'h00000300);
      repeat (8) @(posedge clk);
      count(32);
      chk("fastCore xtal", 32'd8, cnts[8]);
   endtask

   task automatic t_gear();
      logic [2:0] codes[5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h1};
      int divs[5] = '{1, 2, 4, 8, 1};
      for (int i = 0; i < 5; i++) begin
         wr(SYS_CONFIG_ADDR, {29'h0, codes[i]});
         repeat (40) @(posedge clk);
         count(256);
         chk("gear", 64 / divs[i], cnts[7]);
         chk("bus", 64 / divs[i], cnts[5]);
         chk("coreFree", 64 / divs[i], cnts[4]);
      end
   endtask

   task automatic t_tap();
      for (int c = 0; c < 7; c++) begin
         wr(SYS_CONFIG_ADDR, 32'h00001000 | (c << TAP_LSB));
         repeat (140) @(posedge clk);
         count(512);
         chk("tap", (c == 6) ? 128 : 128 >> c, cnts[2]);
         chk("periphBase", 32'd128, cnts[3]);
      end
      wr(SYS_CONFIG_ADDR, 32'h00000000);
   endtask

   task automatic t_lowpower();
      power_state_t st[3] = '{STOP, SLEEP, IDLE};
      wr(OSC_CTRL_ADDR, 32'h00000304);
      for (int c = 0; c < 5; c++) begin
         wr(STANDBY_ADDR, 32'h00000100 | ((c == 4) ? 4 : c));
         pulse(1'b1);
         chk("state", (c >= 1 && c <= 3) ? 32'(st[c - 1]) : 32'(RUN), 32'(powerState));
         count(64);
         chk("bus stopped", (c >= 1 && c <= 3) ? 0 : 16, cnts[5]);
         chk("coreFree stopped", (c >= 1 && c <= 3) ? 0 : 16, cnts[4]);
         if (c == 1) chk("pins inactive", 32'h0, {31'h0, pinsDriven});
         if (c == 2) chk("pll sleep", 32'h0, {31'h0, pll_run});
         if (c == 3) chk("pll idle", 32'h1, {31'h0, pll_run});
         pulse(1'b0);
         chk("wake", 32'(RUN), 32'(powerState));
      end
      wr(OSC_CTRL_ADDR, 32'h00000300);
      wr(STANDBY_ADDR, 32'h00010001);
      pulse(1'b1);
      chk("pins active", 32'h1, {31'h0, pinsDriven});
      pulse(1'b0);
      chk("hi after wake", 32'h0, {31'h0, hiOscRun});
      chk("lo after wake", 32'h0, {31'h0, loOscRun});
      rdChk("osc after wake", OSC_CTRL_ADDR, 32'h00000000);
      wr(STANDBY_ADDR, 32'h00000301);
      pulse(1'b1);
      pulse(1'b0);
      chk("hi on wake", 32'h1, {31'h0, hiOscRun});
      chk("lo on wake", 32'h1, {31'h0, loOscRun});
      wr(STANDBY_ADDR, 32'h00000100);
   endtask

   task automatic t_sysswitch(input logic slow);
      int n;
      n = 0;
      wr(SYS_CLK_SEL_ADDR, {30'h0, slow, 1'b0});
      do begin
         busOp(1'b0, SYS_CLK_SEL_ADDR, 32'h0);
         n++;
      end while (q[0] !== slow && n < 100);
      chk("status", {30'h0, slow, slow}, q);
      count(256);
      chk("sys rate", slow ? 32'd8 : 32'd64, cnts[6]);
      if (slow) chk("slowXtal", 32'd8, cnts[0]);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      #(40 * 60000);
      n_mismatch++;
      final_report();
   end

   initial begin
      nrst = 1'b0;
      avmReq = '0;
      slowXtalPin = 1'b0;
      slowDiv = 4'h0;
      lowPowerEnter = 1'b0;
      wakeUp = 1'b0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_pll();
      t_gear();
      t_tap();
      t_lowpower();
      t_sysswitch(1'b1);
      t_sysswitch(1'b0);
      final_report();
   end
endmodule // clock_select_and_standby_control_bench
`default_nettype wire
